// file: common/legacy_cmd_consts.svh
// Character codes, limits and the pp1e12 scale factor for the legacy serial command parser
`ifndef LEGACY_CMD_CONSTS_SVH
`define LEGACY_CMD_CONSTS_SVH
`define CH_BSLASH 8'h5C
`define CH_LT 8'h3C
`define CH_GT 8'h3E
`define CH_QM 8'h3F
`define CH_CR 8'h0D
`define CH_LF 8'h0A
`define CH_SP 8'h20
`define CH_LBRACE 8'h7B
`define CH_RBRACE 8'h7D
`define CH_PRINT_LO 8'h20
`define CH_PRINT_HI 8'h7E
`define CH_MINUS 8'h2D
`define CH_PLUS 8'h2B
`define CH_0 8'h30
`define CH_9 8'h39
`define CH_UP_A 8'h41
`define CH_LO_A 8'h61
`define CH_UP_C 8'h43
`define CH_SIX 8'h36
`define CH_CARET 8'h5E
`define CH_LO_C 8'h63
`define CH_LO_D 8'h64
`define CH_LO_E 8'h65
`define CH_LO_F 8'h66
`define CH_LO_G 8'h67
`define CH_LO_H 8'h68
`define CH_LO_N 8'h6E
`define CH_LO_S 8'h73
`define CH_LO_X 8'h78
`define CASE_BIT 8'h20
`define ARG_LIM_PP12 32'h0000_4E20
`define ARG_LIM_PP15 32'h0131_2D00
`define SCALE_PP12 48'h0000_0000_03E8
`define FREQ_W 48
`define TELE_VALUES 2'h0
`define TELE_HEADERS 2'h1
`define TELE_CSV 2'h2
`endif

// file: common/legacy_cmd_pkg.sv
// Types shared by the legacy serial command parser
package legacy_cmd_pkg;
   typedef enum logic [2:0] {
      ST_IDLE, ST_F1, ST_F2, ST_ARG, ST_TELE, ST_SEND
   } parse_state_t;
   typedef enum logic [3:0] {
      MSG_ERR, MSG_TUNE_ON, MSG_TUNE_OFF, MSG_APPLY, MSG_SAVE,
      MSG_CENTRE, MSG_ADJ_SET, MSG_ADJ_ADD, MSG_NONE
   } reply_msg_t;
endpackage : legacy_cmd_pkg

// file: verification/host_term_model.sv
// Host terminal model that sinks reply characters with a stall pattern
`timescale 1ns/1ps
module host_term_model (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [7:0] tx_data,
   input wire logic tx_valid,
   output logic tx_ready,
   output logic [7:0] got_byte,
   output logic got_stb
);
   logic [1:0] phase_r;
   // ==========================================
   // Stall pattern
   // Ready two cycles of three, so the parser must hold a character across a stall
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) phase_r <= 2'h0;
      else phase_r <= (phase_r == 2'h2) ? 2'h0 : phase_r + 2'h1;
   end
   assign tx_ready = (phase_r != 2'h1);
   assign got_stb = tx_valid & tx_ready;
   assign got_byte = tx_data;
endmodule : host_term_model

// file: verification/testbench.sv
// Self-checking bench for the legacy serial command parser
`timescale 1ns/1ps
module testbench;
   typedef struct {string cmd; string rep; logic tune; logic [47:0] adj; logic [47:0] cen;} row_t;
   localparam logic [47:0] NEG_LIM = 48'hFFFF_FECE_D300;
   logic clk, rst_n, rx_valid, rx_ready, tx_valid, tx_ready, got_stb, fwd_valid, compat_mode;
   logic analog_tune_en, nv_tune_wr, nv_tune_val, nv_centre_wr, tele_req;
   logic tele_done = 1'b0;
   logic line_done = 1'b0;
   logic [7:0] rx_data, tx_data, fwd_data, got_byte, fwd_seen;
   logic [47:0] centre_freq, digital_adjust;
   logic [1:0] tele_kind, kind_seen;
   int miscompares = 0, comparisons = 0, cycles = 0, nvc_cnt = 0, nvt_cnt = 0, tele_cnt = 0, fwd_cnt = 0;
   string line = "", s, tk = "C6^";
   row_t rows[16];
   legacy_serial_command_parser dut_u (.clk(clk), .rst_n(rst_n), .rx_data(rx_data), .rx_valid(rx_valid),
      .rx_ready(rx_ready), .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .fwd_data(fwd_data),
      .fwd_valid(fwd_valid), .compat_mode(compat_mode), .analog_tune_en(analog_tune_en),
      .nv_tune_wr(nv_tune_wr), .nv_tune_val(nv_tune_val), .nv_centre_wr(nv_centre_wr),
      .centre_freq(centre_freq), .digital_adjust(digital_adjust), .tele_req(tele_req),
      .tele_kind(tele_kind), .tele_done(tele_done));
   host_term_model host_u (.clk(clk), .rst_n(rst_n), .tx_data(tx_data), .tx_valid(tx_valid),
      .tx_ready(tx_ready), .got_byte(got_byte), .got_stb(got_stb));
   // ==========================================
   // Clock, capture and prompt telemetry formatter
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         miscompares++;
         close_out();
      end
      if (got_stb === 1'b1) begin
         chk_val("tx_printable", 48'h1, 48'((got_byte >= 8'h20 && got_byte <= 8'h7E) || got_byte == 8'h0D
            || got_byte == 8'h0A));
         line = {line, string'(got_byte)};
         if (got_byte === 8'h0A) line_done = 1'b1;
      end
      if (nv_centre_wr === 1'b1) nvc_cnt++;
      if (nv_tune_wr === 1'b1) nvt_cnt++;
      if (tele_req === 1'b1) begin
         tele_cnt++;
         kind_seen = tele_kind;
      end
      if (fwd_valid === 1'b1) begin
         fwd_cnt++;
         fwd_seen = fwd_data;
      end
   end
   always @(negedge clk) tele_done = (tele_req === 1'b1);
   // ==========================================
   // Shared tasks
   task automatic chk_val(input string name, input logic [47:0] exp, input logic [47:0] got);
      comparisons++;
      if (got !== exp) begin
         miscompares++;
         $display("Error %s expected %0h seen %0h", name, exp, got);
      end
   endtask : chk_val
   task automatic chk_str(input string name, input string exp, input string got);
      comparisons++;
      if (got != exp) begin
         miscompares++;
         $display("Error %s expected '%s' seen '%s'", name, exp, got);
      end
   endtask : chk_str
   // Holds valid across consecutive characters so it is never written twice in one step
   task automatic send_ch(input logic [7:0] c);
      rx_data = c;
      rx_valid = 1'b1;
      while (rx_ready !== 1'b1) @(negedge clk);
      @(negedge clk);
   endtask : send_ch
   task automatic send_str(input string t);
      for (int i = 0; i < t.len(); i++) send_ch(t[i]);
      rx_valid = 1'b0;
   endtask : send_str
   task automatic get_reply(output string body);
      int n;
      n = 0;
      while (line_done !== 1'b1 && n < 400) begin
         @(negedge clk);
         n++;
      end
      chk_val("reply_end", 48'h0D0A, (line.len() >= 2) ? 48'({line[line.len()-2], line[line.len()-1]}) : 48'h0);
      body = line.substr(0, line.len() - 3);
      line = "";
      line_done = 1'b0;
   endtask : get_reply
   task automatic close_out;
      $display("Counts: comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : close_out
   // ==========================================
   // Main sequence
   initial begin
      rst_n = 1'b0;
      rx_valid = 1'b0;
      rx_data = 8'h00;
      rows = '{'{"A", "TUNE ON", 1'b1, 48'h0, 48'h0}, '{"a", "TUNE OFF", 1'b0, 48'h0, 48'h0},
         '{"<fd5>", "ADJ SET", 1'b0, 48'h1388, 48'h0}, '{"<FE-2>", "ADJ ADDED", 1'b0, 48'hBB8, 48'h0},
         '{"<fh+7>", "ADJ ADDED", 1'b0, 48'hBBF, 48'h0}, '{"<fc99999>", "CENTRE ADJ", 1'b0, 48'hBBF, 48'h131_2D00},
         '{"<ff-30000000>", "CENTRE ADJ", 1'b0, 48'hBBF, 48'h0}, '{"<fa>", "ADJ APPLIED", 1'b0, 48'h0, 48'hBBF},
         '{"<fg-20000001>", "ADJ SET", 1'b0, NEG_LIM, 48'hBBF}, '{"<fs>", "CENTRE SAVED", 1'b0, NEG_LIM, 48'hBBF},
         '{"<nx1>", "TUNE ON", 1'b1, NEG_LIM, 48'hBBF}, '{"<nx0>", "TUNE OFF", 1'b0, NEG_LIM, 48'hBBF},
         '{"<fq1>", "?", 1'b0, NEG_LIM, 48'hBBF}, '{"<fd1x>", "?", 1'b0, NEG_LIM, 48'hBBF},
         '{"z", "?", 1'b0, NEG_LIM, 48'hBBF}, '{"<nx2>", "?", 1'b0, NEG_LIM, 48'hBBF}};
      repeat (5) @(negedge clk);
      rst_n = 1'b1;
      foreach (rows[i]) begin
         send_str(rows[i].cmd);
         get_reply(s);
         chk_str("reply", rows[i].rep, s);
         chk_val("tune", 48'(rows[i].tune), 48'(analog_tune_en));
         chk_val("nv_tune_val", 48'(rows[i].tune), 48'(nv_tune_val));
         chk_val("adjust", rows[i].adj, digital_adjust);
         chk_val("centre", rows[i].cen, centre_freq);
         chk_val("compat", 48'h1, 48'(compat_mode));
      end
      chk_val("nv_centre_writes", 48'h2, 48'(nvc_cnt));
      chk_val("nv_tune_writes", 48'h2, 48'(nvt_cnt));
      // Positive overrun on a pp1e12 increment clamps, cancelling the negative limit exactly
      send_str("<fe25000>");
      get_reply(s);
      chk_str("reply", "ADJ ADDED", s);
      chk_val("adjust", 48'h0, digital_adjust);
      // Backslash in mid-frame escapes back to normal mode, which must stay silent
      send_str("<f\\");
      repeat (8) @(negedge clk);
      chk_val("compat", 48'h0, 48'(compat_mode));
      chk_val("escape_reply_len", 48'h0, 48'(line.len()));
      // Inside braces a legacy key belongs to the newer parser and is forwarded
      send_str("{A}x");
      repeat (2) @(negedge clk);
      chk_val("fwd_data", 48'h78, 48'(fwd_seen));
      chk_val("fwd_count", 48'h4, 48'(fwd_cnt));
      chk_val("compat", 48'h0, 48'(compat_mode));
      // First telemetry key arrives in normal mode and must enter compatibility mode
      for (int k = 0; k < 3; k++) begin
         send_str(tk.substr(k, k));
         get_reply(s);
         chk_str("tele_reply", "", s);
         chk_val("tele_kind", 48'(k), 48'(kind_seen));
         chk_val("tele_count", 48'(k + 1), 48'(tele_cnt));
         chk_val("compat", 48'h1, 48'(compat_mode));
      end
      // Escape from idle, then leave a frame half sent so reset lands mid-command
      send_str("\\");
      repeat (4) @(negedge clk);
      chk_val("compat", 48'h0, 48'(compat_mode));
      send_str("<fd1>");
      get_reply(s);
      chk_val("adjust", 48'h3E8, digital_adjust);
      send_str("<f");
      // Reset in mid-run clears the mode and the frequency state at once
      rst_n = 1'b0;
      #10;
      chk_val("compat_rst", 48'h0, 48'(compat_mode));
      chk_val("centre_rst", 48'h0, centre_freq);
      chk_val("adjust_rst", 48'h0, digital_adjust);
      @(negedge clk);
      rst_n = 1'b1;
      repeat (2) @(negedge clk);
      chk_val("rx_ready_rst", 48'h1, 48'(rx_ready));
      chk_val("compat_rst2", 48'h0, 48'(compat_mode));
      close_out();
   end
endmodule : testbench

// file: verilog/legacy_serial_command_parser.sv
// Legacy single-key and angle-framed command interpreter with reply generator
`timescale 1ns/1ps
`include "legacy_cmd_consts.svh"

// Overview of operation
// R1 - Any legacy command moves the processor into compatibility mode, held in a flag; the code forwards legacy keys inside braces instead.
// R2 - Compatibility mode lasts until a backslash; host escapes before bracketed syntax.
// R3 - Compatibility mode uses per-command reply text, not the bracketed reply framing.
// R4 - Single-character commands act immediately on receipt, no carriage return.
// R5 - Argument commands are framed by less-than and greater-than; run on the closer.
// R6 - Every framed command answers with a string describing its action.
// R7 - Only printable ASCII is exchanged in either direction.
// R8 - Every accepted command replies; each reply line ends in CR then LF.
// R9 - Unsupported or malformed commands answer question mark, CR, LF, nothing else.
// R10 - A enables, a disables analog tuning; framed one/zero also persist it.
// R11 - C shows values, 6 sends telemetry headers, caret sends CSV telemetry.
// R12 - Apply adds digital adjustment into centre frequency, then zeroes the adjustment.
// R13 - Save writes the present centre frequency to the nonvolatile store.
// R14 - Centre add commands add signed argument scaled pp1e12 or pp1e15.
// R15 - Replace commands overwrite digital adjustment with signed scaled argument.
// R16 - Increment commands add signed scaled argument to the digital adjustment.
// R17 - Argument is optional sign then decimal digits; other characters are malformed.
// R18 - Arguments clamp to 20000 for pp1e12 and 20000000 for pp1e15.
module legacy_serial_command_parser (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [7:0] rx_data,
   input wire logic rx_valid,
   output logic rx_ready,
   output logic [7:0] tx_data,
   output logic tx_valid,
   input wire logic tx_ready,
   output logic [7:0] fwd_data,
   output logic fwd_valid,
   output logic compat_mode,
   output logic analog_tune_en,
   output logic nv_tune_wr,
   output logic nv_tune_val,
   output logic nv_centre_wr,
   output logic [`FREQ_W-1:0] centre_freq,
   output logic [`FREQ_W-1:0] digital_adjust,
   output logic tele_req,
   output logic [1:0] tele_kind,
   input wire logic tele_done
);
   localparam int FW = `FREQ_W;

   // ==========================================================
   // Reply text table
   // Length in the top nibble, text right-aligned below it
   function automatic logic [99:0] msg_rom(input legacy_cmd_pkg::reply_msg_t m);
      case (m)
         legacy_cmd_pkg::MSG_ERR: msg_rom = {4'h1, 96'(`CH_QM)};
         legacy_cmd_pkg::MSG_TUNE_ON: msg_rom = {4'h7, 96'("TUNE ON")};
         legacy_cmd_pkg::MSG_TUNE_OFF: msg_rom = {4'h8, 96'("TUNE OFF")};
         legacy_cmd_pkg::MSG_APPLY: msg_rom = {4'hB, 96'("ADJ APPLIED")};
         legacy_cmd_pkg::MSG_SAVE: msg_rom = {4'hC, 96'("CENTRE SAVED")};
         legacy_cmd_pkg::MSG_CENTRE: msg_rom = {4'hA, 96'("CENTRE ADJ")};
         legacy_cmd_pkg::MSG_ADJ_SET: msg_rom = {4'h7, 96'("ADJ SET")};
         legacy_cmd_pkg::MSG_ADJ_ADD: msg_rom = {4'h9, 96'("ADJ ADDED")};
         default: msg_rom = 100'h0;
      endcase
   endfunction : msg_rom

   function automatic logic is_digit(input logic [7:0] c);
      is_digit = (c >= `CH_0) && (c <= `CH_9);
   endfunction : is_digit

   // ==========================================================
   // State
   legacy_cmd_pkg::parse_state_t state_r, state_nxt;
   legacy_cmd_pkg::reply_msg_t msg_r, msg_nxt;
   logic compat_r, compat_nxt;
   logic brace_r, brace_nxt;
   logic tune_r, tune_nxt;
   logic [FW-1:0] centre_r, centre_nxt;
   logic [FW-1:0] adj_r, adj_nxt;
   logic [7:0] l1_r, l1_nxt, l2_r, l2_nxt;
   logic neg_r, neg_nxt, sign_r, sign_nxt, dig_r, dig_nxt, err_r, err_nxt;
   logic [31:0] mag_r, mag_nxt;
   logic [3:0] idx_r, idx_nxt;
   logic rx_ready_r, tx_valid_r, tx_valid_nxt;
   logic [7:0] tx_data_r, tx_data_nxt, fwd_data_r;
   logic fwd_valid_r, fwd_valid_nxt;
   logic nv_tune_wr_r, nv_tune_wr_nxt, nv_centre_wr_r, nv_centre_wr_nxt;
   logic tele_req_r, tele_req_nxt;
   logic [1:0] tele_kind_r, tele_kind_nxt;

   // ==========================================================
   // Character and command decode
   wire acc = rx_valid && rx_ready_r;
   wire [7:0] cl = rx_data | `CASE_BIT;
   wire printable = (rx_data >= `CH_PRINT_LO) && (rx_data <= `CH_PRINT_HI);
   wire is_single = (rx_data == `CH_UP_A) || (rx_data == `CH_LO_A) || (rx_data == `CH_UP_C)
      || (rx_data == `CH_SIX) || (rx_data == `CH_CARET);
   wire is_legacy = is_single || (rx_data == `CH_LT);
   wire quiet = (rx_data == `CH_CR) || (rx_data == `CH_LF) || (rx_data == `CH_SP);
   wire is_f = (l1_r == `CH_LO_F);
   wire pp12 = (l2_r == `CH_LO_C) || (l2_r == `CH_LO_D) || (l2_r == `CH_LO_E);
   wire pp15 = (l2_r == `CH_LO_F) || (l2_r == `CH_LO_G) || (l2_r == `CH_LO_H);
   wire plain = !dig_r && !sign_r;
   wire c_nx = (l1_r == `CH_LO_N) && (l2_r == `CH_LO_X) && dig_r && !sign_r && (mag_r < 32'h2);
   wire c_fa = is_f && (l2_r == `CH_LO_A) && plain;
   wire c_fs = is_f && (l2_r == `CH_LO_S) && plain;
   wire c_arg = is_f && (pp12 || pp15) && dig_r;
   wire c_ok = !err_r && (c_nx || c_fa || c_fs || c_arg);
   wire exec = acc && (state_r == legacy_cmd_pkg::ST_ARG) && (rx_data == `CH_GT);
   wire go = exec && c_ok;

   // Clamp, scale and sign the framed argument
   wire [31:0] lim = pp12 ? `ARG_LIM_PP12 : `ARG_LIM_PP15;
   wire [31:0] clamped = (mag_r > lim) ? lim : mag_r; // R18
   wire [FW-1:0] ext = {16'h0, clamped};
   wire [FW-1:0] scaled = pp12 ? FW'(ext * `SCALE_PP12) : ext;
   wire [FW-1:0] arg_val = neg_r ? FW'(-scaled) : scaled;
   // Growth stops past the largest limit, so long digit runs cannot wrap
   wire [35:0] mag_grow = 36'(mag_r) * 36'hA + 36'(rx_data - `CH_0);
   wire [31:0] mag_next = (mag_r > `ARG_LIM_PP15) ? mag_r : mag_grow[31:0];

   // Reply character selection
   wire [99:0] rom = msg_rom(msg_r);
   wire [3:0] mlen = rom[99:96];
   wire [7:0] mchar = rom[8*(mlen-idx_r-4'h1) +: 8];
   wire tx_free = !tx_valid_r || tx_ready;
   wire [7:0] send_char = (idx_r < mlen) ? mchar : ((idx_r == mlen) ? `CH_CR : `CH_LF); // R8
   wire send_more = idx_r <= (mlen + 4'h1);

   // ==========================================================
   // Next-state logic
   always_comb begin
      state_nxt = state_r;
      msg_nxt = msg_r;
      compat_nxt = compat_r;
      brace_nxt = brace_r;
      tune_nxt = tune_r;
      centre_nxt = centre_r;
      adj_nxt = adj_r;
      l1_nxt = l1_r;
      l2_nxt = l2_r;
      neg_nxt = neg_r;
      sign_nxt = sign_r;
      dig_nxt = dig_r;
      err_nxt = err_r;
      mag_nxt = mag_r;
      idx_nxt = idx_r;
      tx_valid_nxt = tx_valid_r && !tx_ready;
      tx_data_nxt = tx_data_r;
      fwd_valid_nxt = 1'b0;
      nv_tune_wr_nxt = 1'b0;
      nv_centre_wr_nxt = 1'b0;
      tele_req_nxt = 1'b0;
      tele_kind_nxt = tele_kind_r;
      case (state_r)
         legacy_cmd_pkg::ST_IDLE: begin
            if (acc && compat_r && rx_data == `CH_BSLASH) begin
               compat_nxt = 1'b0; // R2
            end else if (acc && !compat_r && (brace_r || !is_legacy)) begin
               // Bracketed syntax and any other non-legacy character go to the newer parser untouched
               fwd_valid_nxt = 1'b1;
               if (rx_data == `CH_LBRACE) begin
                  brace_nxt = 1'b1;
               end else if (rx_data == `CH_RBRACE) begin
                  brace_nxt = 1'b0;
               end
            end else if (acc) begin
               compat_nxt = 1'b1; // R1
               idx_nxt = 4'h0;
               state_nxt = legacy_cmd_pkg::ST_SEND; // R4
               msg_nxt = legacy_cmd_pkg::MSG_ERR; // R9
               if (rx_data == `CH_LT) begin
                  state_nxt = legacy_cmd_pkg::ST_F1;
               end else if (rx_data == `CH_UP_A) begin
                  tune_nxt = 1'b1; // R10
                  msg_nxt = legacy_cmd_pkg::MSG_TUNE_ON; // R3
               end else if (rx_data == `CH_LO_A) begin
                  tune_nxt = 1'b0; // R10
                  msg_nxt = legacy_cmd_pkg::MSG_TUNE_OFF;
               end else if (rx_data == `CH_UP_C || rx_data == `CH_SIX || rx_data == `CH_CARET) begin
                  tele_req_nxt = 1'b1; // R11
                  tele_kind_nxt = (rx_data == `CH_UP_C) ? `TELE_VALUES :
                     ((rx_data == `CH_SIX) ? `TELE_HEADERS : `TELE_CSV);
                  msg_nxt = legacy_cmd_pkg::MSG_NONE;
                  state_nxt = legacy_cmd_pkg::ST_TELE;
               end else if (quiet) begin
                  // Terminal line endings between commands are not errors
                  state_nxt = legacy_cmd_pkg::ST_IDLE;
               end
            end
         end
         legacy_cmd_pkg::ST_F1, legacy_cmd_pkg::ST_F2, legacy_cmd_pkg::ST_ARG: begin
            if (acc && rx_data == `CH_BSLASH) begin
               compat_nxt = 1'b0; // R2
               state_nxt = legacy_cmd_pkg::ST_IDLE;
            end else if (acc && state_r == legacy_cmd_pkg::ST_F1) begin
               l1_nxt = cl;
               err_nxt = !printable || (rx_data == `CH_GT);
               neg_nxt = 1'b0;
               sign_nxt = 1'b0;
               dig_nxt = 1'b0;
               mag_nxt = 32'h0;
               state_nxt = legacy_cmd_pkg::ST_F2;
            end else if (acc && state_r == legacy_cmd_pkg::ST_F2) begin
               l2_nxt = cl;
               err_nxt = err_r || !printable || (rx_data == `CH_GT);
               state_nxt = legacy_cmd_pkg::ST_ARG;
            end else if (exec) begin
               state_nxt = legacy_cmd_pkg::ST_SEND; // R5
               idx_nxt = 4'h0;
               msg_nxt = legacy_cmd_pkg::MSG_ERR; // R9
               if (go && c_nx) begin
                  tune_nxt = mag_r[0]; // R10
                  nv_tune_wr_nxt = 1'b1;
                  msg_nxt = mag_r[0] ? legacy_cmd_pkg::MSG_TUNE_ON : legacy_cmd_pkg::MSG_TUNE_OFF; // R6
               end else if (go && c_fa) begin
                  centre_nxt = centre_r + adj_r; // R12
                  adj_nxt = '0;
                  nv_centre_wr_nxt = 1'b1;
                  msg_nxt = legacy_cmd_pkg::MSG_APPLY;
               end else if (go && c_fs) begin
                  nv_centre_wr_nxt = 1'b1; // R13
                  msg_nxt = legacy_cmd_pkg::MSG_SAVE;
               end else if (go && (l2_r == `CH_LO_C || l2_r == `CH_LO_F)) begin
                  centre_nxt = centre_r + arg_val; // R14
                  msg_nxt = legacy_cmd_pkg::MSG_CENTRE;
               end else if (go && (l2_r == `CH_LO_D || l2_r == `CH_LO_G)) begin
                  adj_nxt = arg_val; // R15
                  msg_nxt = legacy_cmd_pkg::MSG_ADJ_SET;
               end else if (go) begin
                  adj_nxt = adj_r + arg_val; // R16
                  msg_nxt = legacy_cmd_pkg::MSG_ADJ_ADD;
               end
            end else if (acc) begin
               // Sign only before any digit; anything else spoils the frame
               if (is_digit(rx_data)) begin
                  dig_nxt = 1'b1; // R17
                  mag_nxt = mag_next;
               end else if ((rx_data == `CH_MINUS || rx_data == `CH_PLUS) && !sign_r && !dig_r) begin
                  sign_nxt = 1'b1; // R17
                  neg_nxt = (rx_data == `CH_MINUS);
               end else begin
                  err_nxt = 1'b1; // R17
               end
            end
         end
         legacy_cmd_pkg::ST_TELE: begin
            // Telemetry text comes from the formatter; only the line end is ours
            if (tele_done) begin
               idx_nxt = 4'h0;
               state_nxt = legacy_cmd_pkg::ST_SEND;
            end
         end
         legacy_cmd_pkg::ST_SEND: begin
            if (tx_free && send_more) begin
               tx_valid_nxt = 1'b1;
               tx_data_nxt = send_char; // R7
               idx_nxt = idx_r + 4'h1;
            end else if (tx_free) begin
               state_nxt = legacy_cmd_pkg::ST_IDLE;
            end
         end
         default: state_nxt = legacy_cmd_pkg::ST_IDLE;
      endcase
   end

   wire rx_ready_nxt = (state_nxt == legacy_cmd_pkg::ST_IDLE) || (state_nxt == legacy_cmd_pkg::ST_F1)
      || (state_nxt == legacy_cmd_pkg::ST_F2) || (state_nxt == legacy_cmd_pkg::ST_ARG);

   // ==========================================================
   // Registers
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= legacy_cmd_pkg::ST_IDLE;
         msg_r <= legacy_cmd_pkg::MSG_NONE;
         {compat_r, brace_r, tune_r, neg_r, sign_r, dig_r, err_r} <= 7'h00;
         {centre_r, adj_r} <= 96'h0;
         {l1_r, l2_r, mag_r, idx_r} <= 52'h0;
         {rx_ready_r, tx_valid_r, tx_data_r, fwd_valid_r, fwd_data_r} <= 19'h0;
         {nv_tune_wr_r, nv_centre_wr_r, tele_req_r, tele_kind_r} <= 5'h00;
      end else begin
         state_r <= state_nxt;
         msg_r <= msg_nxt;
         {compat_r, brace_r, tune_r} <= {compat_nxt, brace_nxt, tune_nxt};
         {neg_r, sign_r, dig_r, err_r} <= {neg_nxt, sign_nxt, dig_nxt, err_nxt};
         {centre_r, adj_r} <= {centre_nxt, adj_nxt};
         {l1_r, l2_r, mag_r, idx_r} <= {l1_nxt, l2_nxt, mag_nxt, idx_nxt};
         {rx_ready_r, tx_valid_r, tx_data_r} <= {rx_ready_nxt, tx_valid_nxt, tx_data_nxt};
         fwd_valid_r <= fwd_valid_nxt;
         fwd_data_r <= fwd_valid_nxt ? rx_data : fwd_data_r;
         {nv_tune_wr_r, nv_centre_wr_r} <= {nv_tune_wr_nxt, nv_centre_wr_nxt};
         {tele_req_r, tele_kind_r} <= {tele_req_nxt, tele_kind_nxt};
      end
   end

   assign rx_ready = rx_ready_r;
   assign tx_data = tx_data_r;
   assign tx_valid = tx_valid_r;
   assign fwd_data = fwd_data_r;
   assign fwd_valid = fwd_valid_r;
   assign compat_mode = compat_r;
   assign analog_tune_en = tune_r;
   assign nv_tune_wr = nv_tune_wr_r;
   assign nv_tune_val = tune_r;
   assign nv_centre_wr = nv_centre_wr_r;
   assign centre_freq = centre_r;
   assign digital_adjust = adj_r;
   assign tele_req = tele_req_r;
   assign tele_kind = tele_kind_r;

   // ==========================================================
   // Checks
   a_legacy_enters: assert property (@(posedge clk) disable iff (!rst_n) // R1
      acc && !compat_r && !brace_r && state_r == legacy_cmd_pkg::ST_IDLE && rx_data == `CH_UP_A
      |=> compat_r && tune_r) else $error("legacy key did not enter compatibility mode");
   a_escape_exits: assert property (@(posedge clk) disable iff (!rst_n) // R2
      acc && compat_r && rx_data == `CH_BSLASH |=> !compat_r && !fwd_valid_r)
      else $error("backslash did not leave compatibility mode");
   a_single_now: assert property (@(posedge clk) disable iff (!rst_n) // R4
      acc && compat_r && state_r == legacy_cmd_pkg::ST_IDLE && rx_data == `CH_LO_A
      |=> !tune_r ##1 tx_valid_r[*1]) else $error("single key not acted on at once");
   a_frame_runs: assert property (@(posedge clk) disable iff (!rst_n) // R5
      exec |=> state_r == legacy_cmd_pkg::ST_SEND && !rx_ready_r)
      else $error("closing character did not start the reply");
   a_printable_out: assert property (@(posedge clk) disable iff (!rst_n) // R7
      tx_valid_r |-> (tx_data_r >= `CH_PRINT_LO && tx_data_r <= `CH_PRINT_HI)
      || tx_data_r == `CH_CR || tx_data_r == `CH_LF) else $error("non-printable reply byte");
   a_crlf_pair: assert property (@(posedge clk) disable iff (!rst_n) // R8
      tx_valid_r && tx_ready && tx_data_r == `CH_CR |=> tx_valid_r && tx_data_r == `CH_LF)
      else $error("carriage return not followed by line feed");
   a_error_mark: assert property (@(posedge clk) disable iff (!rst_n) // R9
      exec && !c_ok |=> centre_r == $past(centre_r) && adj_r == $past(adj_r)
      ##1 tx_valid_r && tx_data_r == `CH_QM) else $error("malformed frame not answered with mark");
   a_tele_request: assert property (@(posedge clk) disable iff (!rst_n) // R11
      acc && compat_r && state_r == legacy_cmd_pkg::ST_IDLE && rx_data == `CH_SIX
      |=> tele_req_r && tele_kind_r == `TELE_HEADERS) else $error("header request missing");
   a_apply_zero: assert property (@(posedge clk) disable iff (!rst_n) // R12
      go && c_fa |=> adj_r == '0 && centre_r == $past(centre_r) + $past(adj_r) && nv_centre_wr_r)
      else $error("apply did not fold and clear the adjustment");
   a_save_store: assert property (@(posedge clk) disable iff (!rst_n) // R13
      go && c_fs |=> nv_centre_wr_r && centre_r == $past(centre_r))
      else $error("save did not write the store");
   a_replace_adj: assert property (@(posedge clk) disable iff (!rst_n) // R15
      go && is_f && l2_r == `CH_LO_D |=> adj_r == $past(arg_val))
      else $error("replace did not overwrite the adjustment");
   a_clamp_arg: assert property (@(posedge clk) disable iff (!rst_n) // R18
      go && is_f && l2_r == `CH_LO_E && !neg_r && mag_r > `ARG_LIM_PP12
      |=> adj_r == $past(adj_r) + 48'h0000_0131_2D00) else $error("argument not clamped");
endmodule : legacy_serial_command_parser
